// >>> inc/ext_trig_if.sv
// Interface between the register block and the external trigger unit
`timescale 1ns/100ps
interface ext_trig_if #(parameter int N_EXT = 4);
   logic [N_EXT-1:0]   pin;
   logic [2*N_EXT-1:0] cfg;
   logic [N_EXT-1:0]   clr;
   logic [N_EXT-1:0]   req;
   modport ctl  (output pin, output cfg, output clr, input req);
   modport unit (input pin, input cfg, input clr, output req);
endinterface : ext_trig_if

// >>> inc/vic_consts.svh
// Offsets, field positions, reset values and sizes of the interrupt controller
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_IRQ_ACTIVE   12'h000
`define OFF_IRQ_RAW      12'h004
`define OFF_IRQ_EN_SET   12'h008
`define OFF_IRQ_EN_CLR   12'h00c
`define OFF_SOFT_CFG     12'h010
`define OFF_VEC_BASE     12'h014
`define OFF_IRQ_VEC      12'h01c
`define OFF_PRIO_LOW     12'h020
`define OFF_PRIO_MID     12'h024
`define OFF_PRIO_HIGH    12'h028
`define OFF_RESERVED     12'h02c
`define OFF_NEST_CTRL    12'h030
`define OFF_EXT_CFG      12'h034
`define OFF_EXT_CLR      12'h038
`define OFF_IRQ_NEST     12'h03c
`define OFF_FIQ_ACTIVE   12'h100
`define OFF_FIQ_RAW      12'h104
`define OFF_FIQ_EN_SET   12'h108
`define OFF_FIQ_EN_CLR   12'h10c
`define OFF_FIQ_VEC      12'h11c
`define OFF_FIQ_NEST     12'h13c
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define NEST_IRQ_BIT     0
`define NEST_FIQ_BIT     1
`define SOFT_IRQ_BIT     1
`define PRIO_FIELD_W     4
`define VEC_BASE_LSB     6
`define VEC_SLOT_SHIFT   2
`define RST_WORD         32'h0000_0000
`define RST_LEVEL        4'h0
`define SOFT_SRC_IDX     1
`define EXT_SRC_LO       18
`define SRC_TOP          21
`define MID_SRC_LO       8
`define HIGH_SRC_LO      16
`endif

// >>> inc/vic_pkg.sv
// Types shared by the interrupt controller modules
package vic_pkg;
   typedef logic [2:0] prio_t;
   typedef logic [4:0] src_t;
   typedef logic [3:0] level_t;
   typedef enum logic [1:0] {
      TRIG_RISE = 2'b00,
      TRIG_FALL = 2'b01,
      TRIG_HIGH = 2'b10,
      TRIG_LOW  = 2'b11
   } trig_mode_t;
endpackage : vic_pkg

// >>> logic/ext_trigger.sv
// Edge and level detection for the external interrupt inputs
`timescale 1ns/100ps
module ext_trigger
   import vic_pkg::*;
#(
   parameter int N_EXT = 4
)(
   input wire logic   clk,
   input wire logic   rst,
   ext_trig_if.unit   ext
);
   logic [N_EXT-1:0] prev;
   logic [N_EXT-1:0] held;
   logic [N_EXT-1:0] edge_seen;
   logic [N_EXT-1:0] is_level;

   // ----------------------------------------
   // Detection
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < N_EXT; i++) begin
         unique case (trig_mode_t'(ext.cfg[2*i +: 2]))
            TRIG_RISE: begin
               edge_seen[i] = ext.pin[i] & ~prev[i];
               is_level[i]  = 1'b0;
            end
            TRIG_FALL: begin
               edge_seen[i] = ~ext.pin[i] & prev[i];
               is_level[i]  = 1'b0;
            end
            TRIG_HIGH: begin
               edge_seen[i] = ext.pin[i];
               is_level[i]  = 1'b1;
            end
            TRIG_LOW: begin
               edge_seen[i] = ~ext.pin[i];
               is_level[i]  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev <= '0;
      end else begin
         prev <= ext.pin;
      end
   end

   // Edge latch: a new edge beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         held <= '0;
      end else begin
         held <= (held & ~ext.clr) | (edge_seen & ~is_level);
      end
   end

   assign ext.req = (held & ~is_level) | (edge_seen & is_level);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_edge_clear;
      (ext.clr[0] && !edge_seen[0] && !is_level[0]) |=> !held[0];
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge latch not cleared");
endmodule : ext_trigger

// >>> logic/vic_top.sv
// Vectored normal and fast interrupt controller with its register block
`timescale 1ns/100ps
`include "vic_consts.svh"
// Operation
// - Registers sit on the peripheral bus; each access takes two cycles.
// - Raw IRQ register shows every source level, enabled or not.
// - Writing IRQ disable register removes written sources from the IRQ enables.
// - Vector base marks a 64-byte-aligned handler table; vectors are formed from it.
// - IRQ vector register returns the handler address of the highest-priority active IRQ source, whether or not it is being serviced.
// - Each source has a priority 0..7, reset to zero.
// - Priorities split: sources 1-7, 8-15, 16-21 over three registers.
// - Nesting control enables nesting separately for IRQ and FIQ.
// - External inputs configured as rising edge, falling edge or level.
// - Writing edge clear register clears an external edge latch.
// - Nesting status records level (priority plus one) of the request that raised the exception.
// - Raw FIQ register shows every FIQ source, enabled or not.
// - Writing FIQ disable removes sources from FIQ enables only.
// - A fast request is presented ahead of a normal one.
module vic_top
   import vic_pkg::*;
#(
   parameter int N_SRC = 22,
   parameter int N_EXT = 4
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [21:0] int_source,
   input  wire logic [N_EXT-1:0] ext_pin,
   output logic             irq_req,
   output logic             fiq_req
);
   localparam logic [21:0] SRC_MASK = 22'h3f_fffe;

   logic [21:0] irq_en;
   logic [21:0] fiq_en;
   logic [31:0] vec_base;
   logic [31:0] prio_low;
   logic [31:0] prio_mid;
   logic [31:0] prio_high;
   logic [1:0]  nest_ctrl;
   logic [2*N_EXT-1:0] ext_cfg;
   level_t      irq_level;
   level_t      fiq_level;
   logic        soft_req;
   logic [31:0] irq_vec;
   logic [31:0] fiq_vec;
   logic [21:0] raw;
   logic [21:0] irq_act;
   logic [21:0] fiq_act;
   src_t        irq_win;
   src_t        fiq_win;
   level_t      irq_lvl_w;
   level_t      fiq_lvl_w;
   logic        irq_pend;
   logic        fiq_pend;
   logic        wr;
   logic        rd_setup;
   logic        hit;
   logic [31:0] rd_word;

   ext_trig_if #(.N_EXT(N_EXT)) ext ();

   ext_trigger #(.N_EXT(N_EXT)) u_ext (
      .clk (clk),
      .rst (rst),
      .ext (ext.unit)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic prio_t prio_of(input logic [31:0] lo, input logic [31:0] mid,
                                     input logic [31:0] hi, input int s);
      if (s < `MID_SRC_LO)
         return lo[s*`PRIO_FIELD_W +: 3];
      else if (s < `HIGH_SRC_LO)
         return mid[(s-`MID_SRC_LO)*`PRIO_FIELD_W +: 3];
      else
         return hi[(s-`HIGH_SRC_LO)*`PRIO_FIELD_W +: 3];
   endfunction : prio_of

   // Highest priority wins; strict compare keeps the lowest number on a tie
   function automatic src_t pick(input logic [21:0] act, input logic [31:0] lo,
                                 input logic [31:0] mid, input logic [31:0] hi);
      src_t  best;
      prio_t bp;
      best = '0;
      bp   = '0;
      for (int s = 1; s <= `SRC_TOP; s++) begin
         if (act[s] && (best == '0 || prio_of(lo, mid, hi, s) > bp)) begin
            best = src_t'(s);
            bp   = prio_of(lo, mid, hi, s);
         end
      end
      return best;
   endfunction : pick

   function automatic logic [31:0] vec_of(input logic [31:0] base, input src_t s);
      return {base[31:`VEC_BASE_LSB], 6'h00} + {25'h000_0000, s, 2'h0};
   endfunction : vec_of

   function automatic level_t lvl_of(input prio_t p);
      return {1'b0, p} + 4'h1;
   endfunction : lvl_of

   // ----------------------------------------
   // Source gathering and arbitration
   // ----------------------------------------
   assign ext.pin = ext_pin;
   assign ext.cfg = ext_cfg;
   assign ext.clr = (wr && paddr == `OFF_EXT_CLR) ? pwdata[N_EXT-1:0] : '0;

   always_comb begin
      raw = int_source & SRC_MASK;
      raw[`SOFT_SRC_IDX] = soft_req;
      raw[`EXT_SRC_LO +: N_EXT] = ext.req;
   end

   assign irq_act   = raw & irq_en;
   assign fiq_act   = raw & fiq_en;
   assign irq_win   = pick(irq_act, prio_low, prio_mid, prio_high);
   assign fiq_win   = pick(fiq_act, prio_low, prio_mid, prio_high);
   assign irq_lvl_w = lvl_of(prio_of(prio_low, prio_mid, prio_high, int'(irq_win)));
   assign fiq_lvl_w = lvl_of(prio_of(prio_low, prio_mid, prio_high, int'(fiq_win)));

   // With nesting on, only a strictly higher level may interrupt again
   assign irq_pend = (|irq_act) && (!nest_ctrl[`NEST_IRQ_BIT] || irq_lvl_w > irq_level);
   assign fiq_pend = (|fiq_act) && (!nest_ctrl[`NEST_FIQ_BIT] || fiq_lvl_w > fiq_level);

   always_ff @(posedge clk) begin
      if (rst) begin
         fiq_req <= 1'b0;
         irq_req <= 1'b0;
      end else begin
         fiq_req <= fiq_pend;
         irq_req <= irq_pend & ~fiq_pend;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_vec <= `RST_WORD;
         fiq_vec <= `RST_WORD;
      end else begin
         if (irq_win != '0)
            irq_vec <= vec_of(vec_base, irq_win);
         if (fiq_win != '0)
            fiq_vec <= vec_of(vec_base, fiq_win);
      end
   end

   // Capture on the request edge beats a software write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_level <= `RST_LEVEL;
         fiq_level <= `RST_LEVEL;
      end else begin
         if (irq_pend && !fiq_pend && !irq_req)
            irq_level <= irq_lvl_w;
         else if (wr && paddr == `OFF_IRQ_NEST)
            irq_level <= pwdata[3:0];
         if (fiq_pend && !fiq_req)
            fiq_level <= fiq_lvl_w;
         else if (wr && paddr == `OFF_FIQ_NEST)
            fiq_level <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en <= '0;
         fiq_en <= '0;
      end else begin
         if (wr && paddr == `OFF_IRQ_EN_SET)
            irq_en <= irq_en | (pwdata[21:0] & SRC_MASK);
         else if (wr && paddr == `OFF_IRQ_EN_CLR)
            irq_en <= irq_en & ~pwdata[21:0];
         if (wr && paddr == `OFF_FIQ_EN_SET)
            fiq_en <= fiq_en | (pwdata[21:0] & SRC_MASK);
         else if (wr && paddr == `OFF_FIQ_EN_CLR)
            fiq_en <= fiq_en & ~pwdata[21:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prio_low  <= `RST_WORD;
         prio_mid  <= `RST_WORD;
         prio_high <= `RST_WORD;
      end else if (wr) begin
         if (paddr == `OFF_PRIO_LOW)
            prio_low <= pwdata & 32'h7777_7770;
         if (paddr == `OFF_PRIO_MID)
            prio_mid <= pwdata & 32'h7777_7777;
         if (paddr == `OFF_PRIO_HIGH)
            prio_high <= pwdata & 32'h0077_7777;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         vec_base  <= `RST_WORD;
         nest_ctrl <= '0;
         ext_cfg   <= '0;
         soft_req  <= 1'b0;
      end else if (wr) begin
         if (paddr == `OFF_VEC_BASE)
            vec_base <= pwdata;
         if (paddr == `OFF_NEST_CTRL)
            nest_ctrl <= pwdata[1:0];
         if (paddr == `OFF_EXT_CFG)
            ext_cfg <= pwdata[2*N_EXT-1:0];
         if (paddr == `OFF_SOFT_CFG)
            soft_req <= pwdata[`SOFT_IRQ_BIT];
      end
   end

   // Reserved word reads zero and takes no write; no bus error for it
   always_comb begin
      hit     = 1'b1;
      rd_word = `RST_WORD;
      unique case (paddr)
         `OFF_IRQ_ACTIVE: rd_word = {10'h000, irq_act};
         `OFF_IRQ_RAW:    rd_word = {10'h000, raw};
         `OFF_IRQ_EN_SET: rd_word = {10'h000, irq_en};
         `OFF_VEC_BASE:   rd_word = vec_base;
         `OFF_IRQ_VEC:    rd_word = irq_vec;
         `OFF_PRIO_LOW:   rd_word = prio_low;
         `OFF_PRIO_MID:   rd_word = prio_mid;
         `OFF_PRIO_HIGH:  rd_word = prio_high;
         `OFF_NEST_CTRL:  rd_word = {30'h0000_0000, nest_ctrl};
         `OFF_EXT_CFG:    rd_word = 32'(ext_cfg);
         `OFF_IRQ_NEST:   rd_word = {28'h000_0000, irq_level};
         `OFF_FIQ_ACTIVE: rd_word = {10'h000, fiq_act};
         `OFF_FIQ_RAW:    rd_word = {10'h000, raw};
         `OFF_FIQ_EN_SET: rd_word = {10'h000, fiq_en};
         `OFF_FIQ_VEC:    rd_word = fiq_vec;
         `OFF_FIQ_NEST:   rd_word = {28'h000_0000, fiq_level};
         `OFF_IRQ_EN_CLR, `OFF_SOFT_CFG, `OFF_RESERVED,
         `OFF_EXT_CLR, `OFF_FIQ_EN_CLR: rd_word = `RST_WORD;
         default:         hit = 1'b0;
      endcase
   end

   // Read data is sampled in the setup cycle so it is ready in the access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= `RST_WORD;
      end else if (rd_setup) begin
         prdata <= rd_word;
      end
   end

   always_comb begin
      pslverr = psel & penable & ~hit;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_read_raw;
      rd_setup && paddr == `OFF_IRQ_RAW;
   endsequence
   property p_raw_read;
      logic [21:0] v;
      (s_read_raw, v = raw) ##1 (psel && penable) |-> prdata == {10'h000, v};
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

   property p_irq_disable;
      (wr && paddr == `OFF_IRQ_EN_CLR) |=> (irq_en & $past(pwdata[21:0])) == '0;
   endproperty
   a_irq_disable: assert property (p_irq_disable) else $error("irq disable failed");

   property p_fiq_disable;
      (wr && paddr == `OFF_FIQ_EN_CLR) |=> (fiq_en & $past(pwdata[21:0])) == '0 && $stable(irq_en);
   endproperty
   a_fiq_disable: assert property (p_fiq_disable) else $error("fiq disable failed");

   property p_enable_set;
      (wr && paddr == `OFF_IRQ_EN_SET) |=> (irq_en & $past(pwdata[21:0] & SRC_MASK))
                                           == $past(pwdata[21:0] & SRC_MASK);
   endproperty
   a_enable_set: assert property (p_enable_set) else $error("enable set failed");

   property p_fiq_first;
      fiq_req |-> !irq_req;
   endproperty
   a_fiq_first: assert property (p_fiq_first) else $error("irq beside fiq");

   property p_vector;
      (irq_win != '0) |=> irq_vec == vec_of($past(vec_base), $past(irq_win));
   endproperty
   a_vector: assert property (p_vector) else $error("irq vector wrong");

   sequence s_irq_taken;
      !irq_req ##1 irq_req;
   endsequence
   property p_nest_capture;
      logic [3:0] l;
      (!irq_req && irq_pend && !fiq_pend, l = irq_lvl_w) ##1 irq_req |-> irq_level == l;
   endproperty
   a_nest_capture: assert property (p_nest_capture) else $error("nest level not captured");

   property p_nest_block;
      s_irq_taken ##0 nest_ctrl[`NEST_IRQ_BIT] ##1 (irq_lvl_w <= irq_level) |=> !irq_req;
   endproperty
   a_nest_block: assert property (p_nest_block) else $error("nested irq not blocked");

   property p_soft;
      (wr && paddr == `OFF_SOFT_CFG) |=> raw[`SOFT_SRC_IDX] == $past(pwdata[`SOFT_IRQ_BIT]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft source wrong");

   property p_prio_reset;
      $fell(rst) |-> prio_low == '0 && prio_mid == '0 && prio_high == '0;
   endproperty
   a_prio_reset: assert property (@(posedge clk) p_prio_reset) else $error("priority not reset");
endmodule : vic_top

// >>> verif/core_model.sv
// Core-side bus master model that reads and writes the controller registers
`timescale 1ns/100ps
module core_model (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ----------------------------------------
   // Idle bus
   // ----------------------------------------
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end
   // ----------------------------------------
   // One transfer: setup cycle, then access cycle held until ready
   // ----------------------------------------
   // Addresses come from the caller; only refusal scenarios aim at holes
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines show the inverse so stale values never look valid
      paddr   <= ~a;
      pwdata  <= ~d;
      // Idle edge keeps back-to-back calls from driving twice in one step
      @(posedge clk);
   endtask : xfer
endmodule : core_model

// >>> verif/tb_vic_top.sv
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/100ps
`include "vic_consts.svh"
module tb_vic_top;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq_req, fiq_req, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [21:0] int_source;
   logic [3:0]  ext_pin;
   int          errors, num_checks;
   // ----------------------------------------
   // Clock, design and bus master
   // ----------------------------------------
   initial clk = 1'b0;
   always #25 clk = ~clk;
   vic_top #(.N_SRC(22), .N_EXT(4)) u_vic_top (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .int_source(int_source), .ext_pin(ext_pin),
      .irq_req(irq_req), .fiq_req(fiq_req));
   core_model u_core_model (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ----------------------------------------
   // Compare and bus helpers
   // ----------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_word
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk_bit
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_core_model.xfer(1'b1, a, d, q, e);
      chk_bit("write slave error", 1'b0, e);
   endtask : wr
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      u_core_model.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk_word(nm, exp, q);
      chk_bit("read slave error", 1'b0, e);
   endtask : rd
   // Bounded wait on a request output, sampled at rising edges
   task automatic wait_req(input logic fiq, input logic exp, input string nm);
      int   n;
      logic v;
      n = 0;
      v = fiq ? fiq_req : irq_req;
      while (v !== exp && n < 8) begin
         @(posedge clk);
         n++;
         v = fiq ? fiq_req : irq_req;
      end
      chk_bit(nm, exp, v);
   endtask : wait_req
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [11:0] offs [0:15] = '{`OFF_IRQ_ACTIVE, `OFF_IRQ_EN_SET, `OFF_VEC_BASE, `OFF_IRQ_VEC,
         `OFF_PRIO_LOW, `OFF_PRIO_MID, `OFF_PRIO_HIGH, `OFF_RESERVED, `OFF_NEST_CTRL, `OFF_EXT_CFG,
         `OFF_EXT_CLR, `OFF_IRQ_NEST, `OFF_FIQ_ACTIVE, `OFF_FIQ_EN_SET, `OFF_FIQ_VEC, `OFF_FIQ_NEST};
      foreach (offs[i]) rd($sformatf("reset %h", offs[i]), offs[i], `RST_WORD);
      chk_bit("irq idle", 1'b0, irq_req);
      chk_bit("fiq idle", 1'b0, fiq_req);
   endtask : t_reset
   task automatic t_enable();
      int_source <= 22'h000020;
      @(posedge clk);
      rd("raw irq", `OFF_IRQ_RAW, 32'h20);
      rd("active disabled", `OFF_IRQ_ACTIVE, 32'h0);
      wr(`OFF_IRQ_EN_SET, 32'ha0);
      wr(`OFF_IRQ_EN_SET, 32'h08);
      rd("irq enables", `OFF_IRQ_EN_SET, 32'ha8);
      rd("active enabled", `OFF_IRQ_ACTIVE, 32'h20);
      wait_req(1'b0, 1'b1, "irq raised");
      wr(`OFF_IRQ_EN_CLR, 32'h28);
      rd("irq enables cleared", `OFF_IRQ_EN_SET, 32'h80);
      rd("active cleared", `OFF_IRQ_ACTIVE, 32'h0);
      wait_req(1'b0, 1'b0, "irq dropped");
      int_source <= 22'h000000;
      wr(`OFF_IRQ_EN_CLR, 32'h80);
   endtask : t_enable
   task automatic t_fiq();
      int_source <= 22'h000200;
      @(posedge clk);
      rd("raw fiq", `OFF_FIQ_RAW, 32'h200);
      wr(`OFF_FIQ_EN_SET, 32'h200);
      wr(`OFF_IRQ_EN_SET, 32'h200);
      rd("fiq active", `OFF_FIQ_ACTIVE, 32'h200);
      wait_req(1'b1, 1'b1, "fiq raised");
      chk_bit("irq held back", 1'b0, irq_req);
      rd("fiq vector", `OFF_FIQ_VEC, 32'h24);
      rd("fiq level", `OFF_FIQ_NEST, 32'h1);
      wr(`OFF_FIQ_EN_CLR, 32'h200);
      rd("fiq enables", `OFF_FIQ_EN_SET, 32'h0);
      rd("irq enables kept", `OFF_IRQ_EN_SET, 32'h200);
      wait_req(1'b1, 1'b0, "fiq dropped");
      wait_req(1'b0, 1'b1, "irq after fiq");
      int_source <= 22'h000000;
      wr(`OFF_IRQ_EN_CLR, 32'h200);
   endtask : t_fiq
   task automatic t_vector();
      wr(`OFF_VEC_BASE, 32'h1000);
      rd("vector base", `OFF_VEC_BASE, 32'h1000);
      int_source <= 22'h020408;
      wr(`OFF_IRQ_EN_SET, 32'h0002_0408);
      rd("vector equal prio", `OFF_IRQ_VEC, 32'h100c);
      wr(`OFF_PRIO_MID, 32'h500);
      rd("prio mid", `OFF_PRIO_MID, 32'h500);
      rd("vector prio 5", `OFF_IRQ_VEC, 32'h1028);
      wr(`OFF_PRIO_HIGH, 32'h50);
      rd("vector tie", `OFF_IRQ_VEC, 32'h1028);
      wr(`OFF_PRIO_HIGH, 32'h70);
      rd("vector prio 7", `OFF_IRQ_VEC, 32'h1044);
      // Low six base bits must not leak into the vector
      wr(`OFF_VEC_BASE, 32'h1030);
      rd("vector base aligned", `OFF_IRQ_VEC, 32'h1044);
      wr(`OFF_PRIO_LOW, 32'hf000_0000);
      rd("prio three bits", `OFF_PRIO_LOW, 32'h7000_0000);
      int_source <= 22'h000000;
      wr(`OFF_IRQ_EN_CLR, 32'h0002_0408);
   endtask : t_vector
   // Sources 10 and 17 now hold priorities 5 and 7
   task automatic t_nest();
      wr(`OFF_IRQ_NEST, 32'h0);
      wr(`OFF_NEST_CTRL, 32'h1);
      rd("nest control", `OFF_NEST_CTRL, 32'h1);
      wr(`OFF_IRQ_EN_SET, 32'h0002_0400);
      int_source <= 22'h000400;
      wait_req(1'b0, 1'b1, "nested irq");
      wait_req(1'b0, 1'b0, "nested irq taken");
      rd("nested level", `OFF_IRQ_NEST, 32'h6);
      int_source <= 22'h020400;
      wait_req(1'b0, 1'b1, "higher level");
      rd("nested higher", `OFF_IRQ_NEST, 32'h8);
      int_source <= 22'h000000;
      wr(`OFF_IRQ_EN_CLR, 32'h0002_0400);
      // Fast path nesting: stored level 1, source 10 arrives at level 6
      wr(`OFF_NEST_CTRL, 32'h2);
      wr(`OFF_FIQ_EN_SET, 32'h0000_0400);
      int_source <= 22'h000400;
      wait_req(1'b1, 1'b1, "nested fiq");
      wait_req(1'b1, 1'b0, "nested fiq taken");
      rd("fiq nested level", `OFF_FIQ_NEST, 32'h6);
      int_source <= 22'h000000;
      wr(`OFF_FIQ_EN_CLR, 32'h0000_0400);
      wr(`OFF_NEST_CTRL, 32'h0);
      wr(`OFF_IRQ_NEST, 32'h0);
   endtask : t_nest
   task automatic t_ext();
      logic idle [0:3] = '{1'b0, 1'b1, 1'b0, 1'b1};
      wr(`OFF_IRQ_EN_SET, 32'h0004_0000);
      for (int m = 0; m < 4; m++) begin
         ext_pin <= {3'b000, idle[m]};
         wr(`OFF_EXT_CFG, m);
         wr(`OFF_EXT_CLR, 32'h1);
         rd("ext quiet", `OFF_IRQ_ACTIVE, 32'h0);
         ext_pin <= {3'b000, ~idle[m]};
         wait_req(1'b0, 1'b1, "ext trigger");
         ext_pin <= {3'b000, idle[m]};
         wait_req(1'b0, m < 2, "ext after release");
         rd("ext latched", `OFF_IRQ_ACTIVE, (m < 2) ? 32'h0004_0000 : 32'h0);
         wr(`OFF_EXT_CLR, 32'h1);
         rd("ext cleared", `OFF_IRQ_ACTIVE, 32'h0);
         wait_req(1'b0, 1'b0, "ext irq off");
      end
      wr(`OFF_IRQ_EN_CLR, 32'h0004_0000);
   endtask : t_ext
   task automatic t_soft();
      wr(`OFF_IRQ_EN_SET, 32'h2);
      wr(`OFF_SOFT_CFG, 32'h2);
      rd("soft raw", `OFF_IRQ_RAW, 32'h2);
      rd("soft active", `OFF_IRQ_ACTIVE, 32'h2);
      wait_req(1'b0, 1'b1, "soft irq");
      wr(`OFF_SOFT_CFG, 32'h0);
      wait_req(1'b0, 1'b0, "soft irq off");
      rd("soft raw off", `OFF_IRQ_RAW, 32'h0);
   endtask : t_soft
   task automatic t_holes();
      wr(`OFF_RESERVED, 32'hffff_ffff);
      rd("reserved", `OFF_RESERVED, 32'h0);
      wr(`OFF_IRQ_RAW, 32'hffff_ffff);
      rd("raw read only", `OFF_IRQ_RAW, 32'h0);
      u_core_model.xfer(1'b0, 12'h040, 32'h0, q, e);
      chk_word("unmapped data", 32'h0, q);
      chk_bit("unmapped read error", 1'b1, e);
      u_core_model.xfer(1'b1, 12'h200, 32'hffff_ffff, q, e);
      chk_bit("unmapped write error", 1'b1, e);
   endtask : t_holes
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      int_source = 22'h000000;
      ext_pin = 4'h0;
      errors = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_enable();
      t_fiq();
      t_vector();
      t_nest();
      t_ext();
      t_soft();
      t_holes();
      end_sim();
   end
   // About 350 cycles of traffic; 20000 leaves wide margin
   initial begin
      #(50 * 20000);
      errors++;
      end_sim();
   end
endmodule : tb_vic_top
